//--- core/tsc_regs.svh
// register indices, field layouts, reset values and timing for the
// timestamp counter; included by the package users, defines only
`ifndef TSC_REGS_SVH
`define TSC_REGS_SVH

// register indices; the byte address is four times the index
`define TSC_CMD_IDX 16'hB798
`define TSC_START_TIME_IDX 16'hB7B6
`define TSC_START_DATE_IDX 16'hB7B7
`define TSC_TIMEOUT_IDX 16'hB7C5
`define TSC_CNT_LOW_IDX 16'hB800
`define TSC_CNT_HIGH_IDX 16'hB801
`define TSC_STATUS_IDX 16'hB802

// command word fields
`define TSC_CLEAR_CMD 32'h0000_0001
`define TSC_MODE_MASK 32'h0000_0006
`define TSC_MODE_OFF 32'h0000_0000
`define TSC_MODE_FREE 32'h0000_0002
`define TSC_MODE_START 32'h0000_0004
`define TSC_CNT_MASK 32'h0000_0700
`define TSC_CNT_SAMPLE 32'h0000_0100
`define TSC_CNT_RISE 32'h0000_0200
`define TSC_CNT_FALL 32'h0000_0400
`define TSC_FEAT_NONE 32'h0000_0000

// status bits
`define TSC_ST_BUSY 0
`define TSC_ST_TIMEOUT 1
`define TSC_ST_CFG_ERR 2
`define TSC_ST_REF_PRESENT 3
`define TSC_ST_CLKGEN 4

// reset values
`define TSC_CMD_RESET 32'h0000_0100
`define TSC_TIMEOUT_RESET 32'h0000_0000

// one millisecond in sampling clock cycles, rounded down
`define TSC_MS_NS 1000000
`define TSC_CLK_NS 100
`define TSC_MS_CYCLES (`TSC_MS_NS / `TSC_CLK_NS)

`endif

//--- core/tsc_pkg.sv
// types shared by the timestamp counter files
// assumes tsc_regs.svh carries the numeric constants
package tsc_pkg;
    typedef logic [31:0] tsc_word_t;
    typedef enum logic [1:0] {
        tsc_st_idle = 2'b00,
        tsc_st_wait = 2'b01
    } tsc_state_e;
endpackage

//--- core/tsc_ctl_if.sv
// control and readback signals between the timestamp control and counter
// assumes both ends run on the same sampling clock
`timescale 1ns/1ns
interface tsc_ctl_if #(
    parameter int LOW_W = 32,
    parameter int HIGH_W = 32
);
    logic run;
    logic clear;
    logic split;
    logic ref_edge;
    logic [LOW_W-1:0] low;
    logic [HIGH_W-1:0] high;

    modport ctrl (output run, output clear, output split, output ref_edge,
        input low, input high);
    modport cnt (input run, input clear, input split, input ref_edge,
        output low, output high);
endinterface

//--- core/tsc_counter.sv
// timestamp counter proper, full width or split into high and low parts
// assumes ref_edge is already synchronised and qualified by the controller
`timescale 1ns/1ns
module tsc_counter #(
    parameter int LOW_W = 32,
    parameter int HIGH_W = 32
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    tsc_ctl_if.cnt ctl
);
    logic [LOW_W-1:0] low_q;
    logic [HIGH_W-1:0] high_q;
    wire [LOW_W+HIGH_W-1:0] full_inc = {high_q, low_q} + 1'b1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_q <= '0;
            high_q <= '0;
        end else if (ctl.clear) begin
            low_q <= '0;
            high_q <= '0;
        end else if (ctl.run && ctl.split && ctl.ref_edge) begin
            low_q <= '0;
            high_q <= high_q + 1'b1;
        end else if (ctl.run && ctl.split) begin
            low_q <= low_q + 1'b1;
        end else if (ctl.run) begin
            {high_q, low_q} <= full_inc;
        end
    end

    assign ctl.low = low_q;
    assign ctl.high = high_q;
endmodule

//--- core/tsc_top.sv
// timestamp counter control: APB registers, command decode, reference
// clock synchroniser and the clear-with-wait sequence
// assumes card_start and clkgen_active come from logic on pclk, while
// refclk_pin and refclk_present_pin are asynchronous pins
//
// Register access over APB was decided locally.
`timescale 1ns/1ns
`include "tsc_regs.svh"

module tsc_top #(
    parameter int LOW_W = 32,
    parameter int HIGH_W = 32,
    parameter int MS_CYCLES = `TSC_MS_CYCLES
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [19:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // card events
    input wire logic card_start,
    input wire logic clkgen_active,
    // reference clock pins
    input wire logic refclk_pin,
    input wire logic refclk_present_pin
);
    tsc_ctl_if #(.LOW_W(LOW_W), .HIGH_W(HIGH_W)) ctl ();

    tsc_counter #(.LOW_W(LOW_W), .HIGH_W(HIGH_W)) u_counter (
        .pclk(pclk),
        .presetn(presetn),
        .ctl(ctl.cnt)
    );

    function automatic logic [19:0] addr_of(input logic [15:0] idx);
        addr_of = {2'h0, idx, 2'h0};
    endfunction

    function automatic logic hit(input logic [19:0] a,
        input logic [15:0] idx);
        hit = a == addr_of(idx);
    endfunction

    // field extraction, shared by the write path and the stored word
    function automatic logic [31:0] mode_of(input logic [31:0] w);
        mode_of = w & `TSC_MODE_MASK;
    endfunction

    function automatic logic [31:0] clocking_of(input logic [31:0] w);
        clocking_of = w & `TSC_CNT_MASK;
    endfunction

    function automatic logic mode_valid(input logic [31:0] m);
        mode_valid = m == `TSC_MODE_OFF || m == `TSC_MODE_FREE ||
            m == `TSC_MODE_START;
    endfunction

    // register state
    tsc_pkg::tsc_word_t cmd_q;
    tsc_pkg::tsc_word_t start_time_q;
    tsc_pkg::tsc_word_t start_date_q;
    tsc_pkg::tsc_word_t timeout_q;
    tsc_pkg::tsc_word_t prdata_q;
    logic timeout_flag_q;
    logic cfg_err_q;

    // clear sequence state
    tsc_pkg::tsc_state_e state_q;
    tsc_pkg::tsc_state_e state_d;
    logic [31:0] ms_left_q;
    logic [31:0] tick_q;

    // pin synchronisers
    logic ref_s1_q;
    logic ref_s2_q;
    logic ref_prev_q;
    logic pres_s1_q;
    logic pres_s2_q;

    // apb decode
    wire setup = psel && !penable;
    wire access = psel && penable;
    wire hit_cmd = hit(paddr, `TSC_CMD_IDX);
    wire hit_time = hit(paddr, `TSC_START_TIME_IDX);
    wire hit_date = hit(paddr, `TSC_START_DATE_IDX);
    wire hit_tmo = hit(paddr, `TSC_TIMEOUT_IDX);
    wire hit_low = hit(paddr, `TSC_CNT_LOW_IDX);
    wire hit_high = hit(paddr, `TSC_CNT_HIGH_IDX);
    wire hit_stat = hit(paddr, `TSC_STATUS_IDX);
    wire hit_any = hit_cmd || hit_time || hit_date || hit_tmo ||
        hit_low || hit_high || hit_stat;
    // counter words are read-only; a write to them is refused
    wire ro_write = pwrite && (hit_low || hit_high);
    wire wr = access && pwrite && hit_any && !ro_write;
    wire unmapped = !hit_any;
    wire time_wr = wr && hit_time;
    wire date_wr = wr && hit_date;
    wire tmo_wr = wr && hit_tmo;

    // command word checks
    wire [31:0] w_mode = mode_of(pwdata);
    wire [31:0] w_cnt = clocking_of(pwdata);
    wire [31:0] w_rest = pwdata &
        ~(`TSC_MODE_MASK | `TSC_CNT_MASK | `TSC_CLEAR_CMD);
    wire mode_ok = mode_valid(w_mode);
    wire cnt_ok = w_cnt == `TSC_CNT_SAMPLE || w_cnt == `TSC_CNT_RISE ||
        w_cnt == `TSC_CNT_FALL ||
        (w_mode == `TSC_MODE_OFF && w_cnt == 32'h0000_0000);
    wire feat_ok = w_rest == `TSC_FEAT_NONE;
    wire cmd_wr = wr && hit_cmd;
    wire clear_req = cmd_wr && pwdata[0];
    wire cfg_wr = cmd_wr && !pwdata[0];
    // a rejected word leaves the old configuration running, so a bad
    // write cannot stop a counter that is already stamping
    wire cfg_ok = mode_ok && cnt_ok && feat_ok;
    wire cfg_bad = cfg_wr && !cfg_ok;

    // current configuration
    wire [31:0] cur_mode = mode_of(cmd_q);
    wire [31:0] cur_cnt = clocking_of(cmd_q);
    wire enabled = cur_mode != `TSC_MODE_OFF;
    wire use_rise = cur_cnt == `TSC_CNT_RISE;
    wire use_fall = cur_cnt == `TSC_CNT_FALL;
    wire split_on = use_rise || use_fall;

    // reference edge, seen only after two flops and only when present
    // the edge is seen two cycles after the pin moves, so the low part
    // lags the reference by that fixed amount
    wire rise_seen = ref_s2_q && !ref_prev_q;
    wire fall_seen = !ref_s2_q && ref_prev_q;
    wire ref_edge = pres_s2_q &&
        ((use_rise && rise_seen) || (use_fall && fall_seen));

    // clear sequence
    // a clear that arrives while waiting is dropped; software polls busy
    wire busy = state_q == tsc_pkg::tsc_st_wait;
    wire clear_go = clear_req && !busy && clkgen_active;
    wire clear_now = clear_go && !split_on;
    wire wait_go = clear_go && split_on && timeout_q != 32'h0000_0000;
    wire tmo_now = clear_go && split_on && timeout_q == 32'h0000_0000;
    wire tick_wrap = tick_q == 32'h0000_0000;
    wire wait_hit = busy && ref_edge;
    wire wait_expire = busy && !ref_edge && tick_wrap &&
        ms_left_q <= 32'h0000_0001;
    wire start_clear = card_start && cur_mode == `TSC_MODE_START;

    // status flags: the setting event beats a simultaneous clear
    wire stat_wr = wr && hit_stat;
    wire tmo_set = wait_expire || tmo_now;
    wire tmo_clr = stat_wr && pwdata[`TSC_ST_TIMEOUT];
    wire cfg_clr = stat_wr && pwdata[`TSC_ST_CFG_ERR];
    wire timeout_flag_d = tmo_set || (timeout_flag_q && !tmo_clr);
    wire cfg_err_d = cfg_bad || (cfg_err_q && !cfg_clr);

    // next values of the software registers
    wire [31:0] cmd_d = (cfg_wr && cfg_ok) ? pwdata : cmd_q;
    wire [31:0] timeout_d = tmo_wr ? pwdata : timeout_q;

    assign ctl.run = enabled;
    assign ctl.split = split_on;
    assign ctl.ref_edge = ref_edge;
    assign ctl.clear = enabled && (clear_now || wait_hit || start_clear);

    // read data
    wire [31:0] status_word;
    assign status_word[31:5] = 27'h0000000;
    assign status_word[`TSC_ST_BUSY] = busy;
    assign status_word[`TSC_ST_TIMEOUT] = timeout_flag_q;
    assign status_word[`TSC_ST_CFG_ERR] = cfg_err_q;
    assign status_word[`TSC_ST_REF_PRESENT] = pres_s2_q;
    assign status_word[`TSC_ST_CLKGEN] = clkgen_active;
    // the two counter words are not latched together: a high word read
    // after the low word may already have rolled over
    wire [31:0] rd_mux = hit_cmd ? cmd_q :
        hit_time ? start_time_q :
        hit_date ? start_date_q :
        hit_tmo ? timeout_q :
        hit_low ? 32'(ctl.low) :
        hit_high ? 32'(ctl.high) :
        hit_stat ? status_word : 32'h0000_0000;
    wire [31:0] prdata_d = (setup && !pwrite) ? rd_mux : prdata_q;

    // apb answers in the access cycle; read data was captured at setup
    assign pready = access;
    assign pslverr = access && (unmapped || ro_write);
    assign prdata = prdata_q;

    always_comb begin
        state_d = state_q;
        case (state_q)
            tsc_pkg::tsc_st_idle: begin
                if (wait_go) begin
                    state_d = tsc_pkg::tsc_st_wait;
                end
            end
            tsc_pkg::tsc_st_wait: begin
                if (wait_hit || wait_expire) begin
                    state_d = tsc_pkg::tsc_st_idle;
                end
            end
            default: begin
                state_d = tsc_pkg::tsc_st_idle;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_s1_q <= 1'b0;
            ref_s2_q <= 1'b0;
            ref_prev_q <= 1'b0;
        end else begin
            ref_s1_q <= refclk_pin;
            ref_s2_q <= ref_s1_q;
            ref_prev_q <= ref_s2_q;
        end
    end

    // the presence level is an asynchronous pin too
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pres_s1_q <= 1'b0;
            pres_s2_q <= 1'b0;
        end else begin
            pres_s1_q <= refclk_present_pin;
            pres_s2_q <= pres_s1_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_q <= `TSC_CMD_RESET;
        end else begin
            cmd_q <= cmd_d;
        end
    end

    // start date is stored as written by software; start time keeps only its low 24 bits, top byte zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_time_q <= 32'h0000_0000;
        end else if (time_wr) begin
            start_time_q <= {8'h00, pwdata[23:0]};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_date_q <= 32'h0000_0000;
        end else if (date_wr) begin
            start_date_q <= pwdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timeout_q <= `TSC_TIMEOUT_RESET;
        end else begin
            timeout_q <= timeout_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timeout_flag_q <= 1'b0;
        end else begin
            timeout_flag_q <= timeout_flag_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_err_q <= 1'b0;
        end else begin
            cfg_err_q <= cfg_err_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else begin
            prdata_q <= prdata_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= tsc_pkg::tsc_st_idle;
        end else begin
            state_q <= state_d;
        end
    end

    // millisecond timer for the bounded wait on a reference edge
    wire tick_load = wait_go || (busy && tick_wrap);
    wire [31:0] ms_left_d = wait_go ? timeout_q :
        (busy && tick_wrap) ? ms_left_q - 32'h0000_0001 : ms_left_q;
    wire [31:0] tick_d = tick_load ? 32'(MS_CYCLES - 1) :
        busy ? tick_q - 32'h0000_0001 : tick_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ms_left_q <= 32'h0000_0000;
        end else begin
            ms_left_q <= ms_left_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_q <= 32'h0000_0000;
        end else begin
            tick_q <= tick_d;
        end
    end
endmodule

//--- verification/tsc_properties.sv
// apb-side assertions for the timestamp counter, bound to tsc_top
// assumes tsc_regs.svh is on the include path
`timescale 1ns/1ns
`include "tsc_regs.svh"
module tsc_properties (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [19:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    wire [15:0] idx = paddr[17:2];
    wire ok = paddr[19:18] == 2'b00 && paddr[1:0] == 2'b00;
    wire acc = psel && penable;
    wire setup_rd = psel && !penable && !pwrite;
    wire cnt = ok && idx inside {`TSC_CNT_LOW_IDX, `TSC_CNT_HIGH_IDX};
    wire map = cnt || ok && idx inside {`TSC_CMD_IDX, `TSC_STATUS_IDX,
        `TSC_START_TIME_IDX, `TSC_START_DATE_IDX, `TSC_TIMEOUT_IDX};
    sequence s_rd(logic [15:0] x);
        setup_rd && ok && idx == x ##1 acc;
    endsequence
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_access: assert property (psel && !penable ##1 acc |-> pready)
        else $error("pready low in access phase");
    a_err_unmapped: assert property (acc && !map |-> pslverr)
        else $error("no error on unmapped address");
    a_ok_mapped: assert property (acc && map && !(pwrite && cnt) |-> !pslverr)
        else $error("error on a legal access");
    a_count_ro: assert property (acc && pwrite && cnt |-> pslverr)
        else $error("counter word accepted a write");
    a_unmap_zero: assert property (setup_rd && !map ##1 acc |-> prdata == 0)
        else $error("unmapped read not zero");
    a_cmd_fields: assert property (s_rd(`TSC_CMD_IDX) |->
        (prdata & ~(`TSC_MODE_MASK | `TSC_CNT_MASK)) == 0)
        else $error("command reads bits outside its fields");
    a_time_top: assert property (s_rd(`TSC_START_TIME_IDX) |-> prdata[31:24] == 8'h00)
        else $error("start time top byte not zero");
    a_status_rsvd: assert property (s_rd(`TSC_STATUS_IDX) |-> prdata[31:5] == 27'h0)
        else $error("status reserved bits set");
    a_rdata_hold: assert property (!setup_rd |=> $stable(prdata))
        else $error("read data moved without a read");
endmodule
bind tsc_top tsc_properties props (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

//--- verification/tsc_ref_model.sv
// reference clock source, a seconds-like signal from a receiver
// assumes the bench chooses whether the input is fitted
`timescale 1ns/1ns
module tsc_ref_model #(
    parameter int HALF_NS = 20000
) (
    // from the bench
    input wire logic fit,
    // pins
    output logic refclk,
    output logic present
);
    // free running, phase unrelated to pclk; gives both edge kinds
    initial begin
        refclk = 1'b0;
        #13;
        forever #(HALF_NS) refclk = ~refclk;
    end
    // toggles on even when not fitted, so the design must ignore it
    assign present = fit;
endmodule

//--- verification/testbench.sv
// self-checking bench for the timestamp counter over apb
// assumes tsc_regs.svh on the include path; pclk at 10 MHz
`timescale 1ns/1ns
`include "tsc_regs.svh"
module testbench;
    localparam logic [15:0] CMD = `TSC_CMD_IDX, TMO = `TSC_TIMEOUT_IDX;
    localparam logic [15:0] LOW = `TSC_CNT_LOW_IDX, ST = `TSC_STATUS_IDX;
    localparam logic [15:0] HIGH = `TSC_CNT_HIGH_IDX;
    localparam logic [15:0] RWX [3] = '{`TSC_START_TIME_IDX,
        `TSC_START_DATE_IDX, `TSC_TIMEOUT_IDX};
    localparam logic [31:0] CFG [7] = '{32'h0, 32'h102, 32'h104,
        32'h202, 32'h204, 32'h402, 32'h404};
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, card_start = 1'b0, clkgen = 1'b1, fit = 1'b1;
    logic [19:0] paddr = 20'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] seed = 32'h1A262E83;
    logic [31:0] prdata, rd, a, b, v;
    logic pready, pslverr, refclk, present, err;
    int errors = 0;
    int n_checks = 0;
    int i;
    tsc_top #(.MS_CYCLES(4)) dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .card_start(card_start),
        .clkgen_active(clkgen), .refclk_pin(refclk),
        .refclk_present_pin(present));
    tsc_ref_model ref_src (.fit(fit), .refclk(refclk), .present(present));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [31:0] time_of(input logic [31:0] w);
        return w & 32'h00FF_FFFF;
    endfunction
    task automatic xfer(input logic w, input logic [15:0] x,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= 20'({x, 2'b00});
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("BAD %0t exp %h got %h", $time, e, g);
        end
    endtask
    task automatic rng(input logic [31:0] lo, hi, g);
        n_checks++;
        if ((g >= lo && g <= hi) !== 1'b1) begin
            errors++;
            $display("BAD %0t exp %h..%h got %h", $time, lo, hi, g);
        end
    endtask
    task automatic rchk(input logic [15:0] x, input logic [31:0] e);
        xfer(1'b0, x, 32'h0);
        chk(e, rd);
    endtask
    // two low-word reads five cycles apart around a start pulse
    task automatic pulse_pair();
        xfer(1'b0, LOW, 32'h0);
        a = rd;
        @(posedge pclk);
        card_start <= 1'b1;
        @(posedge pclk);
        card_start <= 1'b0;
        xfer(1'b0, LOW, 32'h0);
        b = rd;
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // fixed sample rate throughout, so counts stay comparable
    initial begin
        forever #50 pclk = ~pclk;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        errors++;
        summarize();
    end
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rchk(CMD, `TSC_CMD_RESET);
        rchk(TMO, `TSC_TIMEOUT_RESET);
        xfer(1'b0, 16'hB7A0, 32'h0);
        chk(32'h1, {rd[30:0], err});
        xfer(1'b1, LOW, rnd());
        chk(32'h1, 32'(err));
        xfer(1'b1, CMD, 32'h802);
        rchk(CMD, `TSC_CMD_RESET);
        xfer(1'b0, ST, 32'h0);
        chk(32'h4, rd & 32'h4);
        for (i = 0; i < 7; i++) begin
            xfer(1'b1, CMD, CFG[i]);
            rchk(CMD, CFG[i]);
        end
        xfer(1'b1, ST, 32'h6);
        for (i = 0; i < 3; i++) begin
            v = rnd();
            xfer(1'b1, RWX[i], v);
            rchk(RWX[i], i > 0 ? v : time_of(v));
        end
        xfer(1'b1, CMD, 32'h102);
        xfer(1'b1, CMD, `TSC_CLEAR_CMD);
        xfer(1'b0, LOW, 32'h0);
        rng(32'h0, 32'h3, rd);
        xfer(1'b0, LOW, 32'h0);
        a = rd;
        v = rnd();
        repeat (v[3:0]) @(posedge pclk);
        xfer(1'b0, LOW, 32'h0);
        chk(a + v[3:0] + 32'h3, rd);
        pulse_pair();
        chk(a + 32'h5, b);
        xfer(1'b1, CMD, 32'h104);
        pulse_pair();
        rng(32'h0, 32'h3, b);
        xfer(1'b1, CMD, 32'h102);
        clkgen <= 1'b0;
        xfer(1'b0, LOW, 32'h0);
        a = rd;
        xfer(1'b1, CMD, `TSC_CLEAR_CMD);
        rchk(LOW, a + 32'h6);
        clkgen <= 1'b1;
        xfer(1'b1, TMO, 32'hC8);
        for (i = 0; i < 2; i++) begin
            xfer(1'b1, CMD, i > 0 ? 32'h402 : 32'h202);
            xfer(1'b1, CMD, `TSC_CLEAR_CMD);
            xfer(1'b0, ST, 32'h0);
            chk(32'h1, rd & 32'h3);
            do xfer(1'b0, ST, 32'h0); while (rd[0] === 1'b1);
            chk(32'h0, rd & 32'h2);
            repeat (1000) @(posedge pclk);
            rchk(HIGH, 32'h2);
            xfer(1'b0, LOW, 32'h0);
            rng(32'hC8, 32'h18F, rd);
        end
        fit <= 1'b0;
        xfer(1'b1, TMO, 32'h1);
        xfer(1'b1, CMD, `TSC_CLEAR_CMD);
        repeat (20) @(posedge pclk);
        xfer(1'b0, ST, 32'h0);
        chk(32'h2, rd & 32'hB);
        xfer(1'b0, HIGH, 32'h0);
        a = rd;
        repeat (900) @(posedge pclk);
        rchk(HIGH, a);
        summarize();
    end
endmodule
